//--- rtl/anpr_bank.sv
// Negotiation page register group with its serial management slave.
// Assumes mdc runs at most clk/8 and the negotiation engine shares clk.
`timescale 1ns/10ps

module anpr_bank
   import anpr_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h00
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Management pins
   input  wire logic        mdc,
   input  wire logic        mdioIn,
   output logic             mdioOut,
   output logic             mdioOe,
   // Strap pins
   input  wire logic        pauseStrapPin,
   input  wire logic [1:0]  modeStrapPin,
   // Negotiation engine status
   input  wire logic        lpPageValid,
   input  wire logic [15:0] lpPage,
   input  wire logic        pdFaultDet,
   input  wire logic        partnerAnAble,
   input  wire logic        npSent,
   input  wire logic        npSentToggle,
   // Negotiation engine controls
   output anpr_word_t       advWord,
   output anpr_word_t       npTxWord,
   output logic             anRestart
);
   `include "anpr_regs.svh"

   // Synchronised pins
   logic       mdcS;
   logic       mdioS;
   logic       pauseS;
   logic [1:0] modeS;

   anpr_sync #(.W(5)) uSync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .asyncIn ({mdc, mdioIn, pauseStrapPin, modeStrapPin}),
      .syncOut ({mdcS, mdioS, pauseS, modeS})
   );

   function automatic logic [3:0] techFromMode(input logic [1:0] m);
      unique case (m)
         2'd0: techFromMode = `ANPR_TECH_MODE0;
         2'd1: techFromMode = `ANPR_TECH_MODE1;
         2'd2: techFromMode = `ANPR_TECH_MODE2;
         2'd3: techFromMode = `ANPR_TECH_MODE3;
      endcase
   endfunction

   // Register state
   logic        advNp_r;
   logic        advRf_r;
   logic        advAsym_r;
   logic        advPause_r;
   logic [3:0]  advTech_r;
   logic [4:0]  advSel_r;
   anpr_word_t  lpWord_r;
   logic        lpAnAble_r;
   logic        npNp_r;
   logic        npMsg_r;
   logic        npAck2_r;
   logic        npToggle_r;
   logic [10:0] npCode_r;
   logic        restartPend_r;
   logic [1:0]  strapCnt_r;
   logic        strapDone_r;

   // Frame engine state
   anpr_mdio_e  mdState_r;
   logic        mdcPrev_r;
   logic        mdcRise;
   logic [5:0]  preCnt_r;
   logic [4:0]  bitCnt_r;
   logic [13:0] hdr_r;
   anpr_word_t  shift_r;
   logic        isWrite_r;
   logic        hit_r;
   logic [4:0]  regIdx_r;
   logic        wrStb;
   logic [4:0]  wrIdx;
   anpr_word_t  wrData;
   logic        expClr;
   logic [1:0]  latched;
   anpr_word_t  rdWord;
   logic [13:0] hdrNext;

   assign mdcRise = mdcS & ~mdcPrev_r;
   assign hdrNext = {hdr_r[12:0], mdioS};

   // Latching flags: bit 0 parallel fault, bit 1 page received
   logic [1:0] latchCause;
   // RULE9 Parallel fault cause
   assign latchCause[0] = pdFaultDet;
   // RULE12 Page received cause
   assign latchCause[1] = lpPageValid;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : gLatch
         anpr_latch_flag uFlag (
            .clk     (clk),
            .sys_rst (sys_rst),
            .cause   (latchCause[gi]),
            .readClr (expClr),
            .flag_r  (latched[gi])
         );
      end
   endgenerate

   // Read view of the selected register
   always_comb begin
      rdWord = '0;
      unique case (regIdx_r)
         `ANPR_IDX_CONTROL: begin
            rdWord[`ANPR_BIT_RESTART] = restartPend_r;
         end
         `ANPR_IDX_ADVERT: begin
            rdWord[`ANPR_BIT_NP]     = advNp_r;
            rdWord[`ANPR_BIT_RFAULT] = advRf_r;
            rdWord[`ANPR_BIT_ASYM]   = advAsym_r;
            rdWord[`ANPR_BIT_PAUSE]  = advPause_r;
            rdWord[8:5]              = advTech_r;
            rdWord[4:0]              = advSel_r;
         end
         // RULE6 Partner read view
         `ANPR_IDX_PARTNER: rdWord = lpWord_r;
         `ANPR_IDX_EXPANSION: begin
            rdWord[`ANPR_BIT_PDFAULT]  = latched[0];
            // RULE10 Partner next page
            rdWord[`ANPR_BIT_LPNPABLE] = lpWord_r[`ANPR_BIT_NP];
            // RULE11 No local next page
            rdWord[`ANPR_BIT_NPABLE]   = 1'b0;
            rdWord[`ANPR_BIT_PAGERX]   = latched[1];
            // RULE13 Partner negotiates
            rdWord[`ANPR_BIT_LPANABLE] = lpAnAble_r;
         end
         `ANPR_IDX_NPTX: begin
            rdWord[`ANPR_BIT_NP]      = npNp_r;
            rdWord[`ANPR_BIT_MSGPAGE] = npMsg_r;
            rdWord[`ANPR_BIT_ACK2]    = npAck2_r;
            rdWord[`ANPR_BIT_TOGGLE]  = npToggle_r;
            rdWord[10:0]              = npCode_r;
         end
         // RULE19 Unmapped reads zero
         default: rdWord = '0;
      endcase
   end

   // Frame engine: samples mdio on rising mdc, drives after rising mdc
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mdState_r <= MD_PRE;
         mdcPrev_r <= 1'b0;
         preCnt_r  <= '0;
         bitCnt_r  <= '0;
         hdr_r     <= '0;
         shift_r   <= '0;
         isWrite_r <= 1'b0;
         hit_r     <= 1'b0;
         regIdx_r  <= '0;
         mdioOut   <= 1'b0;
         mdioOe    <= 1'b0;
      end else begin
         mdcPrev_r <= mdcS;
         if (mdcRise) begin
            unique case (mdState_r)
               MD_PRE: begin
                  if (mdioS) begin
                     if (preCnt_r != `ANPR_PREAMBLE_LEN) begin
                        preCnt_r <= preCnt_r + 6'd1;
                     end
                  end else if (preCnt_r == `ANPR_PREAMBLE_LEN) begin
                     hdr_r     <= hdrNext;
                     bitCnt_r  <= 5'd1;
                     mdState_r <= MD_HDR;
                  end else begin
                     preCnt_r <= '0;
                  end
               end
               MD_HDR: begin
                  hdr_r    <= hdrNext;
                  bitCnt_r <= bitCnt_r + 5'd1;
                  if (bitCnt_r == 5'(`ANPR_HDR_BITS - 4'd1)) begin
                     // Start 01, then opcode, phy address, register
                     isWrite_r <= (hdrNext[11:10] == 2'b01);
                     hit_r     <= (hdrNext[13:12] == 2'b01) &&
                                  (hdrNext[11] != hdrNext[10]) &&
                                  (hdrNext[9:5] == PHY_ADDR);
                     regIdx_r  <= hdrNext[4:0];
                     bitCnt_r  <= '0;
                     mdState_r <= MD_TA;
                  end
               end
               MD_TA: begin
                  if (hit_r && !isWrite_r) begin
                     mdioOe    <= 1'b1;
                     mdioOut   <= 1'b0;
                     shift_r   <= rdWord;
                     mdState_r <= MD_RD;
                  end else begin
                     bitCnt_r  <= 5'd1;
                     mdState_r <= MD_WR;
                  end
               end
               MD_RD: begin
                  if (bitCnt_r == `ANPR_DATA_BITS) begin
                     mdioOe    <= 1'b0;
                     mdioOut   <= 1'b0;
                     preCnt_r  <= '0;
                     mdState_r <= MD_PRE;
                  end else begin
                     mdioOut  <= shift_r[15];
                     shift_r  <= {shift_r[14:0], 1'b0};
                     bitCnt_r <= bitCnt_r + 5'd1;
                  end
               end
               MD_WR: begin
                  shift_r  <= {shift_r[14:0], mdioS};
                  bitCnt_r <= bitCnt_r + 5'd1;
                  if (bitCnt_r == `ANPR_WR_BITS) begin
                     preCnt_r  <= '0;
                     mdState_r <= MD_PRE;
                  end
               end
            endcase
         end
      end
   end

   // Write commit on the last data bit; read clear when data is loaded
   assign wrStb  = mdcRise && (mdState_r == MD_WR) && (bitCnt_r == `ANPR_WR_BITS) &&
                   hit_r && isWrite_r;
   assign wrIdx  = regIdx_r;
   assign wrData = {shift_r[14:0], mdioS};
   // RULE18 Clear on read
   assign expClr = mdcRise && (mdState_r == MD_TA) && hit_r && !isWrite_r &&
                   (regIdx_r == `ANPR_IDX_EXPANSION);

   // Straps settle through the synchroniser, then seed the advertisement
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         strapCnt_r  <= '0;
         strapDone_r <= 1'b0;
      end else if (!strapDone_r) begin
         strapCnt_r  <= strapCnt_r + 2'd1;
         strapDone_r <= (strapCnt_r == `ANPR_STRAP_WAIT);
      end
   end

   // Advertisement register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         advNp_r    <= 1'b0;
         advRf_r    <= 1'b0;
         advAsym_r  <= 1'b0;
         advPause_r <= 1'b0;
         advTech_r  <= '0;
         advSel_r   <= `ANPR_RST_SELECTOR;
      end else if (!strapDone_r && strapCnt_r == `ANPR_STRAP_WAIT) begin
         // RULE4 Pause from strap
         advPause_r <= pauseS;
         // RULE5 Abilities from straps
         advTech_r  <= techFromMode(modeS);
      end else if (wrStb && wrIdx == `ANPR_IDX_ADVERT) begin
         // RULE1 Writable next page
         advNp_r    <= wrData[`ANPR_BIT_NP];
         // RULE2 Remote fault flag
         advRf_r    <= wrData[`ANPR_BIT_RFAULT];
         // RULE3 Asymmetric pause
         advAsym_r  <= wrData[`ANPR_BIT_ASYM];
         advPause_r <= wrData[`ANPR_BIT_PAUSE];
         advTech_r  <= wrData[8:5];
         advSel_r   <= wrData[4:0];
      end
   end

   // Partner page capture
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // RULE6 Selector reset value
         lpWord_r   <= `ANPR_RST_PARTNER;
         lpAnAble_r <= 1'b0;
      end else begin
         lpAnAble_r <= partnerAnAble;
         if (lpPageValid) begin
            // RULE7 Acknowledge on capture
            // RULE8 T4 passes through
            lpWord_r <= (lpPage & `ANPR_MASK_PARTNER) | (16'h0001 << `ANPR_BIT_ACK);
         end
      end
   end

   // Next page transmit register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         npNp_r     <= 1'b0;
         npMsg_r    <= `ANPR_RST_MSGPAGE;
         npAck2_r   <= 1'b0;
         npToggle_r <= 1'b0;
         npCode_r   <= `ANPR_RST_MSGCODE;
      end else begin
         if (wrStb && wrIdx == `ANPR_IDX_NPTX) begin
            // RULE14 Writable page fields
            npNp_r   <= wrData[`ANPR_BIT_NP];
            npMsg_r  <= wrData[`ANPR_BIT_MSGPAGE];
            npCode_r <= wrData[10:0];
            // RULE15 Comply flag
            npAck2_r <= wrData[`ANPR_BIT_ACK2];
         end
         // RULE16 Inverse of sent toggle
         if (npSent) begin
            npToggle_r <= ~npSentToggle;
         end
      end
   end

   // Restart: pending for one cycle, then clears itself
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         restartPend_r <= 1'b0;
         anRestart     <= 1'b0;
      end else begin
         // RULE17 Self-clearing restart
         restartPend_r <= wrStb && wrIdx == `ANPR_IDX_CONTROL &&
                          wrData[`ANPR_BIT_RESTART];
         anRestart     <= restartPend_r;
      end
   end

   // Words handed to the negotiation engine
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         advWord  <= '0;
         npTxWord <= '0;
      end else begin
         // RULE1 No next-page exchange offered
         // RULE2 Remote fault sent out
         advWord  <= {1'b0, 1'b0, advRf_r, 1'b0, advAsym_r, advPause_r, 1'b0,
                      advTech_r, advSel_r};
         npTxWord <= {npNp_r, 1'b0, npMsg_r, npAck2_r, npToggle_r, npCode_r};
      end
   end
endmodule // anpr_bank

//--- rtl/anpr_regs.svh
// Constants of the negotiation page register group: indices, bit positions,
// reset values, strap decodes and management frame counts.
// Assumes inclusion by bare name from the package and the register bank.
// Behaviour
// RULE1: Advert bit 15 writable, resets zero, never used
// RULE2: Advert bit 13 remote fault, writable, sent out
// RULE3: Advert bit 11 asymmetric pause, writable, resets zero
// RULE4: Advert bit 10 pause, reset from strap
// RULE5: Advert bits 8:5 writable, reset from mode straps
// RULE6: Partner register read-only, captured page, selector 00001b
// RULE7: Partner bit 14 set once code word received
// RULE8: Partner T4 reported only, never offered locally
// RULE9: Expansion bit 4 latches parallel detection fault
// RULE10: Expansion bit 3 shows partner next-page ability
// RULE11: Expansion bit 2 local next-page ability, zero
// RULE12: Expansion bit 1 latches new page received
// RULE13: Expansion bit 0 shows partner negotiation ability
// RULE14: Next-page bits 15, 13, 10:0 writable, defaults
// RULE15: Next-page bit 12 comply flag, writable, zero
// RULE16: Next-page bit 11 reads inverse of sent toggle
// RULE17: Restart bit write restarts negotiation, self-clears
// RULE18: Latched flags clear on read unless cause persists
// RULE19: Reserved bits read zero, ignore writes
`ifndef ANPR_REGS_SVH
`define ANPR_REGS_SVH

// Register indices
`define ANPR_IDX_CONTROL   5'h00
`define ANPR_IDX_ADVERT    5'h04
`define ANPR_IDX_PARTNER   5'h05
`define ANPR_IDX_EXPANSION 5'h06
`define ANPR_IDX_NPTX      5'h07

// Field positions
`define ANPR_BIT_RESTART   9
`define ANPR_BIT_NP        15
`define ANPR_BIT_ACK       14
`define ANPR_BIT_RFAULT    13
`define ANPR_BIT_MSGPAGE   13
`define ANPR_BIT_ACK2      12
`define ANPR_BIT_ASYM      11
`define ANPR_BIT_TOGGLE    11
`define ANPR_BIT_PAUSE     10
`define ANPR_BIT_PDFAULT   4
`define ANPR_BIT_LPNPABLE  3
`define ANPR_BIT_NPABLE    2
`define ANPR_BIT_PAGERX    1
`define ANPR_BIT_LPANABLE  0

// Reset values
`define ANPR_RST_SELECTOR  5'h01
`define ANPR_RST_PARTNER   16'h0001
`define ANPR_RST_MSGCODE   11'h001
`define ANPR_RST_MSGPAGE   1'b1
// Partner bits that hold captured data: 15:13, 10:0
`define ANPR_MASK_PARTNER  16'he7ff

// Technology ability (100FD,100,10FD,10) per mode strap code
`define ANPR_TECH_MODE0    4'h1
`define ANPR_TECH_MODE1    4'h3
`define ANPR_TECH_MODE2    4'hc
`define ANPR_TECH_MODE3    4'hf

// Management frame counts
`define ANPR_PREAMBLE_LEN  6'd32
`define ANPR_HDR_BITS      4'd14
`define ANPR_DATA_BITS     5'd16
`define ANPR_WR_BITS       5'd17
`define ANPR_STRAP_WAIT    2'd2

`endif

//--- rtl/anpr_pkg.sv
// Types shared by the negotiation page register group.
// Assumes the constants header sits beside it.
`include "anpr_regs.svh"

package anpr_pkg;
   typedef logic [15:0] anpr_word_t;

   // Management frame phases
   typedef enum logic [2:0] {
      MD_PRE,
      MD_HDR,
      MD_TA,
      MD_RD,
      MD_WR
   } anpr_mdio_e;
endpackage : anpr_pkg

//--- rtl/anpr_sync.sv
// Two-flop level synchroniser for pins from outside the clock domain.
// Assumes each bit is an independent level.
`timescale 1ns/10ps

module anpr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Levels
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r  <= '0;
         syncOut <= '0;
      end else begin
         meta_r  <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule // anpr_sync

//--- rtl/anpr_latch_flag.sv
// Latching-high status flag, cleared by a register read.
// Assumes the cause and the read pulse are on the same clock.
`timescale 1ns/10ps

module anpr_latch_flag (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Cause and read
   input  wire logic cause,
   input  wire logic readClr,
   output logic      flag_r
);
   // RULE18 Set beats clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= cause | (flag_r & ~readClr);
      end
   end
endmodule // anpr_latch_flag

//--- verification/anpr_bank_monitor.sv
// Assertions on the negotiation page register group ports.
// Assumes one clock domain and a bind onto every anpr_bank instance.
`timescale 1ns/10ps

module anpr_bank_monitor
   import anpr_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // Engine side
   input wire logic       npSent,
   input wire logic       npSentToggle,
   input wire anpr_word_t advWord,
   input wire anpr_word_t npTxWord,
   input wire logic       anRestart
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_adv_np_off: assert property (advWord[15] == 1'b0)
      else $error("advert next page reached engine");
   chk_adv_rsvd_zero: assert property (advWord[14] == 1'b0 && advWord[12] == 1'b0)
      else $error("advert reserved bit set");
   chk_no_t4_offer: assert property (advWord[9] == 1'b0)
      else $error("T4 offered locally");
   chk_np_rsvd_zero: assert property (npTxWord[14] == 1'b0)
      else $error("next page reserved bit set");
   // Toggle register, then the engine word: two edges of lag
   chk_toggle_inverse: assert property (npSent |-> ##2 npTxWord[11] == !$past(npSentToggle, 2))
      else $error("toggle not inverse of sent value");
   // Toggle is read-only, so only a sent page may move it
   chk_toggle_cause: assert property ($changed(npTxWord[11]) |-> $past(npSent, 2))
      else $error("toggle moved without a sent page");
   chk_restart_pulse: assert property (anRestart |=> !anRestart)
      else $error("restart not self clearing");
   chk_np_reset_val: assert property ($fell(sys_rst) |-> ##[0:1] npTxWord == 16'h2001)
      else $error("next page reset value wrong");
   chk_adv_reset_val: assert property ($fell(sys_rst) |-> ##[0:4]
      (advWord[4:0] == 5'h01 && advWord[13:11] == 3'b000))
      else $error("advert reset value wrong");
endmodule // anpr_bank_monitor

bind anpr_bank anpr_bank_monitor u_anpr_bank_monitor (
   .clk(clk), .sys_rst(sys_rst), .npSent(npSent), .npSentToggle(npSentToggle),
   .advWord(advWord), .npTxWord(npTxWord), .anRestart(anRestart));

//--- verification/anpr_mgmt_model.sv
// Station management controller model: sends one frame per start pulse.
// Assumes the bank syncs mdc, so each mdc phase lasts 8 clk; line has a pull-up.
`timescale 1ns/10ps

module anpr_mgmt_model (
   // Clock
   input  wire logic        clk,
   // Management pins
   input  wire logic        mdioOut,
   input  wire logic        mdioOe,
   output logic             mdc,
   output logic             mdioIn,
   // Requests
   input  wire logic        start,
   input  wire logic        wr,
   input  wire logic [4:0]  regIdx,
   input  wire logic [15:0] wdata,
   output logic [15:0]      rdata,
   output logic             done
);
   logic        drv;
   logic        bitV;
   logic [63:0] frame;

   // Released line floats high, never holds the last bit
   assign mdioIn = mdioOe ? mdioOut : (drv ? bitV : 1'b1);

   initial begin
      mdc   = 1'b0;
      drv   = 1'b0;
      bitV  = 1'b1;
      rdata = 16'h0000;
      done  = 1'b0;
      forever begin
         @(posedge clk);
         done <= 1'b0;
         if (start) begin
            frame = {32'hffff_ffff, 2'b01, wr ? 2'b01 : 2'b10, 5'h00, regIdx, 2'b10, wdata};
            for (int i = 0; i < 64; i++) begin
               // Read turnaround hands the line to the bank
               drv  <= wr || (i < 46);
               bitV <= frame[63-i];
               repeat (8) @(posedge clk);
               mdc <= 1'b1;
               repeat (8) @(posedge clk);
               mdc <= 1'b0;
               if (!wr && i >= 47 && i <= 62) begin
                  rdata[62-i] = mdioIn;
               end
            end
            drv <= 1'b0;
            repeat (8) @(posedge clk);
            done <= 1'b1;
         end
      end
   end
endmodule // anpr_mgmt_model

//--- verification/test_anpr_bank.sv
// Self-checking bench for the negotiation page register group.
// Assumes the management model file and the bank's default address 0.
`timescale 1ns/10ps

module test_anpr_bank;
   logic        clk, sys_rst, mdc, mdioIn, mdioOut, mdioOe, pauseStrapPin;
   logic        lpPageValid, pdFaultDet, partnerAnAble, npSent, npSentToggle;
   logic        anRestart, start, wr, done, tog;
   logic [1:0]  modeStrapPin;
   logic [4:0]  regIdx;
   logic [15:0] lpPage, advWord, npTxWord, wdata, rdata, q, d, page, exp;
   int          fails, samples_checked, cycles, restarts;

   anpr_bank u_anpr_bank (.clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdioIn(mdioIn),
      .mdioOut(mdioOut), .mdioOe(mdioOe), .pauseStrapPin(pauseStrapPin),
      .modeStrapPin(modeStrapPin), .lpPageValid(lpPageValid), .lpPage(lpPage),
      .pdFaultDet(pdFaultDet), .partnerAnAble(partnerAnAble), .npSent(npSent),
      .npSentToggle(npSentToggle), .advWord(advWord), .npTxWord(npTxWord),
      .anRestart(anRestart));
   anpr_mgmt_model u_anpr_mgmt_model (.clk(clk), .mdioOut(mdioOut), .mdioOe(mdioOe),
      .mdc(mdc), .mdioIn(mdioIn), .start(start), .wr(wr), .regIdx(regIdx),
      .wdata(wdata), .rdata(rdata), .done(done));

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (anRestart === 1'b1) restarts++;
      if (cycles == 80000) begin
         fails++;
         conclude();
      end
   end

   task automatic conclude();
      $display("compared %0d mismatched %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
      samples_checked++;
      if (got !== want) begin
         fails++;
         $display("BAD %0t %s got %h want %h", $time, what, got, want);
      end
   endtask

   task automatic access(input logic w, input logic [4:0] idx, input logic [15:0] wd);
      wr     <= w;
      regIdx <= idx;
      wdata  <= wd;
      start  <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      while (done !== 1'b1) @(posedge clk);
      q = rdata;
   endtask

   // Technology bits 8:5 chosen by the mode straps
   function automatic logic [3:0] techOf(input logic [1:0] m);
      case (m)
         2'b00: return 4'h1;
         2'b01: return 4'h3;
         2'b10: return 4'hc;
         default: return 4'hf;
      endcase
   endfunction

   initial begin
      {clk, pauseStrapPin, lpPageValid, pdFaultDet, partnerAnAble} = 5'h00;
      {npSent, npSentToggle, start, wr, modeStrapPin, regIdx} = 11'h000;
      {lpPage, wdata} = 32'h0000_0000;
      sys_rst = 1'b1;
      void'($urandom(32'hdd69));
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         sys_rst       <= 1'b1;
         modeStrapPin  <= 2'(m);
         pauseStrapPin <= 1'($urandom);
         repeat (10) @(posedge clk);
         sys_rst <= 1'b0;
         repeat (8) @(posedge clk);
         exp = {5'h00, pauseStrapPin, 1'b0, techOf(2'(m)), 5'h01};
         access(1'b0, 5'h04, 16'h0000);
         check(q, exp, "advert reset");
         check(advWord, exp, "advert to engine");
         access(1'b0, 5'h05, 16'h0000);
         check(q, 16'h0001, "partner reset");
         access(1'b0, 5'h06, 16'h0000);
         check(q, 16'h0000, "expansion reset");
         access(1'b0, 5'h07, 16'h0000);
         check(q, 16'h2001, "next page reset");
         $display("reset test with mode %0d done", m);
      end
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 16'hffff : 16'($urandom);
         access(1'b1, 5'h04, d);
         access(1'b0, 5'h04, 16'h0000);
         check(q, d & 16'hadff, "advert write");
         check(advWord, d & 16'h2dff, "advert to engine");
         tog = 1'($urandom);
         npSent       <= 1'b1;
         npSentToggle <= tog;
         @(posedge clk);
         npSent <= 1'b0;
         access(1'b1, 5'h07, d);
         access(1'b0, 5'h07, 16'h0000);
         exp = (d & 16'hb7ff) | {4'h0, ~tog, 11'h000};
         check(q, exp, "next page write");
         check(npTxWord, exp, "next page to engine");
         access(1'b1, 5'h05, d);
         access(1'b0, 5'h05, 16'h0000);
         check(q, 16'h0001, "partner write ignored");
         access(1'b1, 5'h1f, d);
         access(1'b0, 5'h1f, 16'h0000);
         check(q, 16'h0000, "unmapped read");
      end
      $display("write test done");
      page = 16'($urandom);
      partnerAnAble <= 1'b1;
      lpPage        <= page;
      lpPageValid   <= 1'b1;
      @(posedge clk);
      lpPageValid <= 1'b0;
      access(1'b0, 5'h05, 16'h0000);
      check(q, (page | 16'h4000) & 16'he7ff, "partner capture");
      access(1'b0, 5'h06, 16'h0000);
      check(q, {12'h000, page[15], 3'b011}, "page received");
      access(1'b0, 5'h06, 16'h0000);
      check(q, {12'h000, page[15], 3'b001}, "page flag cleared");
      pdFaultDet <= 1'b1;
      @(posedge clk);
      pdFaultDet <= 1'b0;
      access(1'b0, 5'h06, 16'h0000);
      check(q, {11'h000, 1'b1, page[15], 3'b001}, "fault latched");
      access(1'b0, 5'h06, 16'h0000);
      check(q, {12'h000, page[15], 3'b001}, "fault cleared");
      $display("partner test done");
      restarts = 0;
      access(1'b1, 5'h00, 16'h0200);
      check(16'(restarts), 16'h0001, "restart pulses");
      access(1'b0, 5'h00, 16'h0000);
      check(q, 16'h0000, "restart self cleared");
      $display("restart test done");
      conclude();
   end
endmodule // test_anpr_bank
